// *** hw/iex_pkg.sv ***
// constants shared by the instruction execute subset block
package iex_pkg;
	// ==========================================================
	// register byte offsets
	localparam logic [7:0] OFF_OPCODE   = 8'h00;
	localparam logic [7:0] OFF_FILE_IN  = 8'h04;
	localparam logic [7:0] OFF_ACC      = 8'h08;
	localparam logic [7:0] OFF_STATUS   = 8'h0C;
	localparam logic [7:0] OFF_PC       = 8'h10;
	localparam logic [7:0] OFF_UPPER_PC = 8'h14;
	localparam logic [7:0] OFF_FILE_OUT = 8'h18;
	localparam logic [7:0] OFF_CYCLES   = 8'h1C;
	// ==========================================================
	// field positions
	localparam int STAT_ZERO_BIT   = 0;
	localparam int STAT_SKIP_BIT   = 1;
	localparam int FOUT_ADDR_LSB   = 8;
	localparam int FOUT_VALID_BIT  = 16;
	localparam int DEST_BIT        = 7;
	localparam int UPC_LO_BIT      = 3;
	// ==========================================================
	// opcode classes, bits 13:8 or 13:11
	localparam logic [5:0] OPC_DEC_SKIP = 6'h0B;
	localparam logic [5:0] OPC_INC_SKIP = 6'h0F;
	localparam logic [5:0] OPC_INC      = 6'h0A;
	localparam logic [5:0] OPC_OR_REG   = 6'h04;
	localparam logic [5:0] OPC_OR_LIT   = 6'h38;
	localparam logic [2:0] OPC_JUMP     = 3'h5;
	// ==========================================================
	// reset values, counts and bus response codes
	localparam logic [7:0]  RST_ACC    = 8'h00;
	localparam logic [12:0] RST_PC     = 13'h0000;
	localparam logic [4:0]  RST_UPC    = 5'h00;
	localparam logic [15:0] CYC_ONE    = 16'h0001;
	localparam logic [15:0] CYC_TWO    = 16'h0002;
	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// *** hw/iex_core.sv ***
// instruction execute subset with an axi4-lite register slave
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module iex_core #(
	parameter int ADDR_W = 8
) (
	input  wire logic              clk_sys,
	input  wire logic              rstn,
	input  wire logic              ce,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	output logic                   file_wr_en,
	output logic [6:0]             file_wr_addr,
	output logic [7:0]             file_wr_data
);
	// ==========================================================
	// state
	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        arready;
		logic        aw_hold;
		logic [7:0]  aw_addr;
		logic        w_hold;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [7:0]  acc;
		logic        zero;
		logic [12:0] pc;
		logic [4:0]  upper_pc;
		logic [7:0]  file_in;
		logic        skip;
		logic [15:0] cycles;
		logic        fwr_en;
		logic        fout_valid;
		logic [6:0]  faddr;
		logic [7:0]  fdata;
	} iex_state_t;

	iex_state_t s;
	iex_state_t next_s;

	// ==========================================================
	// write channel join and decode
	logic        aw_ok;
	logic        w_ok;
	logic        do_wr;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic        exec;
	logic [13:0] op;
	logic        is_dec;
	logic        is_incs;
	logic        is_inc;
	logic        is_orr;
	logic        is_orl;
	logic        is_jmp;
	logic        is_fop;
	logic        dest_f;
	logic [7:0]  res;

	assign aw_ok   = s.aw_hold | (s_axi_awvalid & s.awready);
	assign w_ok    = s.w_hold | (s_axi_wvalid & s.wready);
	assign do_wr   = aw_ok & w_ok & ~s.bvalid;
	assign wr_addr = s.aw_hold ? s.aw_addr : s_axi_awaddr[7:0];
	assign wr_data = s.w_hold ? s.w_data : s_axi_wdata;
	assign wr_strb = s.w_hold ? s.w_strb : s_axi_wstrb;
	assign exec    = do_wr & (wr_addr == iex_pkg::OFF_OPCODE)
		& wr_strb[0] & wr_strb[1];
	assign op      = s.skip ? 14'h0000 : wr_data[13:0];
	assign is_dec  = op[13:8] == iex_pkg::OPC_DEC_SKIP;
	assign is_incs = op[13:8] == iex_pkg::OPC_INC_SKIP;
	assign is_inc  = op[13:8] == iex_pkg::OPC_INC;
	assign is_orr  = op[13:8] == iex_pkg::OPC_OR_REG;
	assign is_orl  = op[13:8] == iex_pkg::OPC_OR_LIT;
	assign is_jmp  = op[13:11] == iex_pkg::OPC_JUMP;
	assign is_fop  = is_dec | is_incs | is_inc | is_orr;
	assign dest_f  = op[iex_pkg::DEST_BIT];

	// result datapath, wraps modulo 256
	always_comb begin
		if (is_dec) begin
			res = s.file_in - 8'h01;
		end else if (is_incs | is_inc) begin
			res = s.file_in + 8'h01;
		end else if (is_orr) begin
			res = s.acc | s.file_in;
		end else begin
			res = s.acc | op[7:0];
		end
	end

	// ==========================================================
	// next state
	always_comb begin
		next_s = s;
		next_s.fwr_en = 1'b0;
		if (s_axi_awvalid & s.awready) begin
			next_s.aw_hold = 1'b1;
			next_s.aw_addr = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid & s.wready) begin
			next_s.w_hold = 1'b1;
			next_s.w_data = s_axi_wdata;
			next_s.w_strb = s_axi_wstrb;
		end
		if (s.bvalid & s_axi_bready) begin
			next_s.bvalid = 1'b0;
		end
		if (do_wr) begin
			next_s.aw_hold = 1'b0;
			next_s.w_hold  = 1'b0;
			next_s.bvalid  = 1'b1;
			next_s.bresp   = iex_pkg::RESP_OKAY;
			unique case (wr_addr)
				iex_pkg::OFF_OPCODE: begin
				end
				iex_pkg::OFF_FILE_IN: begin
					if (wr_strb[0]) next_s.file_in = wr_data[7:0];
				end
				iex_pkg::OFF_ACC: begin
					if (wr_strb[0]) next_s.acc = wr_data[7:0];
				end
				iex_pkg::OFF_PC: begin
					if (wr_strb[0]) next_s.pc[7:0] = wr_data[7:0];
					if (wr_strb[1]) next_s.pc[12:8] = wr_data[12:8];
				end
				iex_pkg::OFF_UPPER_PC: begin
					if (wr_strb[0]) next_s.upper_pc = wr_data[4:0];
				end
				default: next_s.bresp = iex_pkg::RESP_SLVERR;
			endcase
		end
		if (exec) begin
			next_s.pc     = s.pc + 13'h0001;
			next_s.cycles = s.cycles + iex_pkg::CYC_ONE;
			next_s.skip   = 1'b0;
			if (is_fop) begin
				if (dest_f) begin
					next_s.fwr_en     = 1'b1;
					next_s.fout_valid = 1'b1;
					next_s.faddr      = op[6:0];
					next_s.fdata      = res;
				end else begin
					next_s.acc = res;
				end
			end
			if ((is_dec | is_incs) & (res == 8'h00)) begin
				next_s.skip = 1'b1;
			end
			if (is_inc | is_orr | is_orl) begin
				next_s.zero = (res == 8'h00);
			end
			if (is_orl) begin
				next_s.acc = res;
			end
			if (is_jmp) begin
				next_s.pc = {s.upper_pc[4:iex_pkg::UPC_LO_BIT],
					op[10:0]};
				next_s.cycles = s.cycles + iex_pkg::CYC_TWO;
			end
		end
		if (s.rvalid & s_axi_rready) begin
			next_s.rvalid = 1'b0;
		end
		if (s_axi_arvalid & s.arready) begin
			next_s.rvalid = 1'b1;
			next_s.rresp  = iex_pkg::RESP_OKAY;
			next_s.rdata  = 32'h0000_0000;
			unique case (s_axi_araddr[7:0])
				iex_pkg::OFF_OPCODE: begin
				end
				iex_pkg::OFF_FILE_IN: next_s.rdata[7:0] = s.file_in;
				iex_pkg::OFF_ACC: next_s.rdata[7:0] = s.acc;
				iex_pkg::OFF_STATUS: begin
					next_s.rdata[iex_pkg::STAT_ZERO_BIT] = s.zero;
					next_s.rdata[iex_pkg::STAT_SKIP_BIT] = s.skip;
				end
				iex_pkg::OFF_PC: next_s.rdata[12:0] = s.pc;
				iex_pkg::OFF_UPPER_PC: next_s.rdata[4:0] = s.upper_pc;
				iex_pkg::OFF_FILE_OUT: begin
					next_s.rdata[7:0] = s.fdata;
					next_s.rdata[iex_pkg::FOUT_ADDR_LSB +: 7] = s.faddr;
					next_s.rdata[iex_pkg::FOUT_VALID_BIT] = s.fout_valid;
				end
				iex_pkg::OFF_CYCLES: next_s.rdata[15:0] = s.cycles;
				default: next_s.rresp = iex_pkg::RESP_SLVERR;
			endcase
		end
		next_s.awready = ~next_s.aw_hold & ~next_s.bvalid;
		next_s.wready  = ~next_s.w_hold & ~next_s.bvalid;
		next_s.arready = ~next_s.rvalid;
	end

	// ==========================================================
	// registers
	always_ff @(posedge clk_sys) begin
		if (!rstn) begin
			s          <= '0;
			s.awready  <= 1'b1;
			s.wready   <= 1'b1;
			s.arready  <= 1'b1;
			s.acc      <= iex_pkg::RST_ACC;
			s.pc       <= iex_pkg::RST_PC;
			s.upper_pc <= iex_pkg::RST_UPC;
		end else if (ce) begin
			s <= next_s;
		end
	end

	assign s_axi_awready = s.awready;
	assign s_axi_wready  = s.wready;
	assign s_axi_arready = s.arready;
	assign s_axi_bvalid  = s.bvalid;
	assign s_axi_bresp   = s.bresp;
	assign s_axi_rvalid  = s.rvalid;
	assign s_axi_rdata   = s.rdata;
	assign s_axi_rresp   = s.rresp;
	assign file_wr_en    = s.fwr_en;
	assign file_wr_addr  = s.faddr;
	assign file_wr_data  = s.fdata;

	// ==========================================================
	// checks
	logic ex_ce;
	assign ex_ce = exec & ce;

	property p_dest_acc;
		@(posedge clk_sys) disable iff (!rstn)
		(ex_ce && is_fop && !dest_f) |=>
			(s.acc == $past(res)) && !file_wr_en;
	endproperty
	a_dest_acc: assert property (p_dest_acc)
		else $error("accumulator destination not written");

	property p_dest_file;
		@(posedge clk_sys) disable iff (!rstn)
		(ex_ce && is_fop && dest_f) |=> file_wr_en
			&& (file_wr_data == $past(res)) && $stable(s.acc);
	endproperty
	a_dest_file: assert property (p_dest_file)
		else $error("file destination not written");

	property p_dec_flags;
		@(posedge clk_sys) disable iff (!rstn)
		(ex_ce && is_dec) |=> $stable(s.zero)
			&& (s.skip == ($past(s.file_in) == 8'h01))
			&& (($past(dest_f) ? file_wr_data : s.acc)
				== 8'($past(s.file_in) - 8'h01));
	endproperty
	a_dec_flags: assert property (p_dec_flags)
		else $error("decrement result or flag wrong");

	property p_skip_nop;
		@(posedge clk_sys) disable iff (!rstn)
		(ex_ce && s.skip) |=> !s.skip && $stable(s.acc)
			&& $stable(s.zero) && !file_wr_en
			&& (s.pc == 13'($past(s.pc) + 13'h0001));
	endproperty
	a_skip_nop: assert property (p_skip_nop)
		else $error("skipped instruction not replaced by nop");

	property p_incs;
		@(posedge clk_sys) disable iff (!rstn)
		(ex_ce && is_incs) |=> $stable(s.zero)
			&& (s.skip == ($past(res) == 8'h00));
	endproperty
	a_incs: assert property (p_incs)
		else $error("increment skip behaviour wrong");

	property p_jump_target;
		@(posedge clk_sys) disable iff (!rstn)
		(ex_ce && is_jmp) |=> s.pc ==
			{$past(s.upper_pc[4:3]), $past(op[10:0])};
	endproperty
	a_jump_target: assert property (p_jump_target)
		else $error("jump target wrong");

	property p_jump_cycles;
		@(posedge clk_sys) disable iff (!rstn)
		(ex_ce && is_jmp) |=> $stable(s.zero)
			&& (s.cycles == 16'($past(s.cycles) + 16'h0002));
	endproperty
	a_jump_cycles: assert property (p_jump_cycles)
		else $error("jump cycle count or flag wrong");

	property p_or_lit;
		@(posedge clk_sys) disable iff (!rstn)
		(ex_ce && is_orl) |=>
			s.acc == ($past(s.acc) | $past(op[7:0]));
	endproperty
	a_or_lit: assert property (p_or_lit)
		else $error("or literal result wrong");

	property p_inc_zero;
		@(posedge clk_sys) disable iff (!rstn)
		(ex_ce && is_inc) |=>
			s.zero == (8'($past(s.file_in) + 8'h01) == 8'h00);
	endproperty
	a_inc_zero: assert property (p_inc_zero)
		else $error("increment zero flag wrong");

	property p_or_reg;
		@(posedge clk_sys) disable iff (!rstn)
		(ex_ce && is_orr) |=> (($past(dest_f) ? file_wr_data : s.acc)
			== ($past(s.acc) | $past(s.file_in)));
	endproperty
	a_or_reg: assert property (p_or_reg)
		else $error("or register result wrong");

	property p_zero_flag;
		@(posedge clk_sys) disable iff (!rstn)
		(ex_ce && (is_inc || is_orr || is_orl)) |=>
			s.zero == ($past(res) == 8'h00);
	endproperty
	a_zero_flag: assert property (p_zero_flag)
		else $error("zero flag does not follow result");
endmodule

// *** test/iex_testbench.sv ***
// self-checking bench for the instruction execute subset block
`timescale 1ns/1ps
module testbench;
	logic        clk_sys, rstn, ce;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready;
	logic        s_axi_arvalid, s_axi_rready;
	logic [31:0] s_axi_wdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic        file_wr_en;
	logic [6:0]  file_wr_addr;
	logic [7:0]  file_wr_data;
	int          failures, n_checks, n_fwr;
	logic [12:0] exp_pc;
	logic [15:0] exp_cyc;
	logic [31:0] rd;
	logic [1:0]  rr;

	iex_core #(.ADDR_W(8)) uut (.clk_sys(clk_sys), .rstn(rstn), .ce(ce),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .file_wr_en(file_wr_en),
		.file_wr_addr(file_wr_addr), .file_wr_data(file_wr_data));

	// ==========================================================
	// clock, file write pulse counter
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		if (file_wr_en === 1'b1) n_fwr <= n_fwr + 1;
	end

	// ==========================================================
	// verdict and bus tasks
	task automatic report_and_stop;
		if (failures == 0 && n_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(posedge clk_sys);
			if (!aw_done && s_axi_awready === 1'b1) begin
				aw_done = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_done && s_axi_wready === 1'b1) begin
				w_done = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end
		do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axi_wr(a, d, rr);
		chk("bresp", {30'h0, iex_pkg::RESP_OKAY}, {30'h0, rr});
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e,
		input string nm);
		axi_rd(a, rd, rr);
		chk(nm, e, rd);
		chk("rresp", {30'h0, iex_pkg::RESP_OKAY}, {30'h0, rr});
	endtask

	// executes one opcode and advances the expected pc and cycle count
	task automatic ex(input logic [13:0] op, input logic [15:0] cyc);
		wr(iex_pkg::OFF_OPCODE, {18'h0_0000, op});
		exp_pc = exp_pc + 13'h0001;
		exp_cyc = exp_cyc + cyc;
	endtask

	function automatic logic [13:0] fop(input logic [5:0] c, input logic d,
		input logic [6:0] f);
		return {c, d, f};
	endfunction

	// ==========================================================
	// watchdog
	initial begin
		repeat (20000) @(posedge clk_sys);
		failures++;
		report_and_stop();
	end

	// ==========================================================
	// tests
	initial begin
		failures = 0; n_checks = 0; n_fwr = 0; exp_pc = 13'h0000;
		exp_cyc = 16'h0000; rstn = 1'b0; ce = 1'b1; s_axi_wstrb = 4'hF;
		s_axi_awaddr = 8'h00; s_axi_araddr = 8'h00; s_axi_wdata = 32'h0;
		s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
		s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
		repeat (16) @(posedge clk_sys);
		rstn <= 1'b1;
		rdc(iex_pkg::OFF_ACC, 32'h0, "acc");
		rdc(iex_pkg::OFF_STATUS, 32'h0, "status");
		rdc(iex_pkg::OFF_PC, 32'h0, "pc");
		rdc(iex_pkg::OFF_FILE_OUT, 32'h0, "file_out");
		axi_rd(8'h20, rd, rr);
		chk("unmapped rresp", 32'h2, {30'h0, rr});
		axi_wr(8'h24, 32'h0000_00FF, rr);
		chk("unmapped bresp", 32'h2, {30'h0, rr});
		ex({iex_pkg::OPC_OR_LIT, 8'h00}, 16'h0001);
		rdc(iex_pkg::OFF_STATUS, 32'h1, "zero");
		ex({iex_pkg::OPC_OR_LIT, 8'h5A}, 16'h0001);
		rdc(iex_pkg::OFF_ACC, 32'h5A, "acc or lit");
		rdc(iex_pkg::OFF_STATUS, 32'h0, "zero");
		wr(iex_pkg::OFF_FILE_IN, 32'h81);
		ex(fop(iex_pkg::OPC_OR_REG, 1'b0, 7'h10), 16'h0001);
		rdc(iex_pkg::OFF_ACC, 32'hDB, "acc or reg");
		wr(iex_pkg::OFF_FILE_IN, 32'hFF);
		ex(fop(iex_pkg::OPC_INC, 1'b0, 7'h10), 16'h0001);
		rdc(iex_pkg::OFF_ACC, 32'h00, "acc inc wrap");
		rdc(iex_pkg::OFF_STATUS, 32'h1, "zero");
		chk("no file write", 32'h0, n_fwr);
		wr(iex_pkg::OFF_FILE_IN, 32'h41);
		ex(fop(iex_pkg::OPC_INC, 1'b1, 7'h25), 16'h0001);
		rdc(iex_pkg::OFF_FILE_OUT, 32'h0001_2542, "file_out");
		chk("file write", 32'h1, n_fwr);
		chk("file_wr_addr", 32'h25, {25'h0, file_wr_addr});
		chk("file_wr_data", 32'h42, {24'h0, file_wr_data});
		rdc(iex_pkg::OFF_ACC, 32'h00, "acc kept");
		rdc(iex_pkg::OFF_STATUS, 32'h0, "zero");
		wr(iex_pkg::OFF_FILE_IN, 32'h00);
		ex(fop(iex_pkg::OPC_OR_REG, 1'b1, 7'h11), 16'h0001);
		rdc(iex_pkg::OFF_FILE_OUT, 32'h0001_1100, "file_out");
		rdc(iex_pkg::OFF_STATUS, 32'h1, "zero");
		wr(iex_pkg::OFF_FILE_IN, 32'h01);
		ex(fop(iex_pkg::OPC_DEC_SKIP, 1'b0, 7'h05), 16'h0001);
		rdc(iex_pkg::OFF_STATUS, 32'h3, "skip, zero kept");
		ex({iex_pkg::OPC_OR_LIT, 8'hFF}, 16'h0001);
		rdc(iex_pkg::OFF_ACC, 32'h00, "acc after nop");
		rdc(iex_pkg::OFF_STATUS, 32'h1, "skip done");
		wr(iex_pkg::OFF_FILE_IN, 32'h00);
		ex(fop(iex_pkg::OPC_DEC_SKIP, 1'b1, 7'h7F), 16'h0001);
		rdc(iex_pkg::OFF_FILE_OUT, 32'h0001_7FFF, "dec wrap");
		rdc(iex_pkg::OFF_STATUS, 32'h1, "no skip");
		ex({iex_pkg::OPC_OR_LIT, 8'h30}, 16'h0001);
		rdc(iex_pkg::OFF_ACC, 32'h30, "acc runs");
		wr(iex_pkg::OFF_FILE_IN, 32'hFF);
		ex(fop(iex_pkg::OPC_INC_SKIP, 1'b1, 7'h02), 16'h0001);
		rdc(iex_pkg::OFF_FILE_OUT, 32'h0001_0200, "inc skip");
		rdc(iex_pkg::OFF_STATUS, 32'h2, "skip");
		ex({iex_pkg::OPC_JUMP, 11'h123}, 16'h0001);
		rdc(iex_pkg::OFF_PC, {19'h0, exp_pc}, "pc after nop");
		wr(iex_pkg::OFF_FILE_IN, 32'h10);
		ex(fop(iex_pkg::OPC_INC_SKIP, 1'b0, 7'h02), 16'h0001);
		rdc(iex_pkg::OFF_ACC, 32'h11, "acc inc skip");
		rdc(iex_pkg::OFF_STATUS, 32'h0, "no skip");
		wr(iex_pkg::OFF_ACC, 32'h00);
		ex({iex_pkg::OPC_OR_LIT, 8'h00}, 16'h0001);
		wr(iex_pkg::OFF_UPPER_PC, 32'h18);
		ex({iex_pkg::OPC_JUMP, 11'h5A5}, 16'h0002);
		rdc(iex_pkg::OFF_PC, 32'h1DA5, "pc jump");
		rdc(iex_pkg::OFF_STATUS, 32'h1, "jump flags");
		wr(iex_pkg::OFF_UPPER_PC, 32'h07);
		ex({iex_pkg::OPC_JUMP, 11'h7FF}, 16'h0002);
		rdc(iex_pkg::OFF_PC, 32'h07FF, "pc jump");
		// opcode write without both low lanes must not execute
		s_axi_wstrb <= 4'h1;
		wr(iex_pkg::OFF_OPCODE,
			{18'h0_0000, iex_pkg::OPC_OR_LIT, 8'hFF});
		s_axi_wstrb <= 4'hF;
		rdc(iex_pkg::OFF_ACC, 32'h00, "acc lane guard");
		rdc(iex_pkg::OFF_PC, 32'h07FF, "pc lane guard");
		rdc(iex_pkg::OFF_CYCLES, {16'h0, exp_cyc}, "cycles");
		// reset again in mid-run
		rstn <= 1'b0;
		repeat (2) @(posedge clk_sys);
		rstn <= 1'b1;
		rdc(iex_pkg::OFF_PC, 32'h0, "pc after reset");
		rdc(iex_pkg::OFF_STATUS, 32'h0, "status after reset");
		rdc(iex_pkg::OFF_CYCLES, 32'h0, "cycles after reset");
		rdc(iex_pkg::OFF_FILE_OUT, 32'h0, "file_out after reset");
		chk("file_wr_data reset", 32'h0, {24'h0, file_wr_data});
		report_and_stop();
	end
endmodule
